// file: logic/asu_pkg.sv
package asu_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_BAUD = 8'h0d;
  localparam logic [7:0] IDX_CTLA = 8'h0e;
  localparam logic [7:0] IDX_CTLB = 8'h0f;
  localparam logic [7:0] IDX_STAT = 8'h10;
  localparam logic [7:0] IDX_DATA = 8'h11;
  localparam logic [7:0] ADDR_BAUD = 8'(IDX_BAUD * 8'h04);
  localparam logic [7:0] ADDR_CTLA = 8'(IDX_CTLA * 8'h04);
  localparam logic [7:0] ADDR_CTLB = 8'(IDX_CTLB * 8'h04);
  localparam logic [7:0] ADDR_STAT = 8'(IDX_STAT * 8'h04);
  localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 8'h04);

  // decoder codes
  localparam logic [2:0] SEL_BAUD = 3'h0;
  localparam logic [2:0] SEL_CTLA = 3'h1;
  localparam logic [2:0] SEL_CTLB = 3'h2;
  localparam logic [2:0] SEL_STAT = 3'h3;
  localparam logic [2:0] SEL_DATA = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // serial_control_a fields
  localparam int CTLA_R8   = 7;
  localparam int CTLA_T8   = 6;
  localparam int CTLA_M    = 4;
  localparam int CTLA_WAKE = 3;

  // serial_control_b fields
  localparam int CTLB_TIE  = 7;
  localparam int CTLB_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int CTLB_RIE  = 5;
  localparam int CTLB_IDLE_IRQ_ENABLE = 4;
  localparam int CTLB_TE   = 3;
  localparam int CTLB_RE   = 2;
  localparam int CTLB_RWU  = 1;
  localparam int CTLB_SBK  = 0;

  // reset values
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic       TX_BUFFER_EMPTY_FLAG_RST = 1'h1;
  localparam logic       TC_RST   = 1'h1;

  // character and sampling timing
  localparam logic [3:0] BITS_8      = 4'ha;
  localparam logic [3:0] BITS_9      = 4'hb;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [7:0] SAMPLES_BIT = 8'h10;
  localparam logic [3:0] PH_LAST     = 4'hf;
  localparam logic [3:0] PH_VOTE_A   = 4'h7;
  localparam logic [3:0] PH_VOTE_B   = 4'h8;
  localparam logic [3:0] PH_VOTE_C   = 4'h9;
  localparam logic [7:0] IDLE_THR_8  = 8'({4'h0, BITS_8} * SAMPLES_BIT);
  localparam logic [7:0] IDLE_THR_9  = 8'({4'h0, BITS_9} * SAMPLES_BIT);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asu_rx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asu_apb_rsp_t;

  typedef struct packed {
    asu_apb_rsp_t  rsp;
    logic [7:0]    baud;
    logic          t8;
    logic          m;
    logic          wake;
    logic          r8;
    logic [7:0]    ctlb;
    logic          tx_buffer_empty_flag;
    logic          tc;
    logic          rx_buffer_full_flag;
    logic          idle;
    logic          ovr;
    logic          nf;
    logic          fe;
    logic          arm_tx;
    logic          arm_rx;
    logic [7:0]    tx_buf;
    logic [7:0]    rx_buf;
    logic [7:0]    div;
    logic [3:0]    tx_ph;
    logic [10:0]   tx_sh;
    logic [3:0]    tx_cnt;
    logic          tx_pin;
    logic          tx_oe;
    logic          tx_line_idle;
    logic          pre_pend;
    logic          last_brk;
    logic          te_prev;
    asu_rx_state_t rx_st;
    logic [3:0]    rx_ph;
    logic [3:0]    rx_bit;
    logic [8:0]    rx_sh;
    logic          rx_s7;
    logic          rx_s8;
    logic          rx_noise;
    logic [7:0]    ones_cnt;
    logic          idle_armed;
    logic          irq;
  } asu_state_t;

endpackage

// file: logic/asu_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - transmit 8 or 9 bit characters per length bit; ninth bit from tx_ninth_bit.
// - shift register sends characters on tx pin, fed from write-only data buffer.
// - enabling transmitter sends a ones preamble before any buffered data.
// - loaded data gets a 0 start bit at lsb and 1 stop bit.
// - buffer-empty flag sets when buffer moves into shift register.
// - tx pin rests at 1 whenever no character is being shifted.
// - clearing enable while idle with buffer empty releases the tx pin.
// - while send_break is set, all-zero break characters repeat at character length.
// - after break clears, finish current break then send at least one 1.
// - idle character is all ones at character length; preamble is one.
// - clearing enable mid transmission keeps pin until last pending character ends.
// - enable toggled on during last character queues an idle preamble.
// - complete flag sets when buffer and shifter empty and nothing generated.
// - receive 8 or 9 bit characters; ninth bit to rx_ninth_bit field.
// - finished character goes to data buffer and sets buffer-full flag.
// - wakeup enable puts receiver in standby with receiver interrupts held off.
// - idle-line wakeup leaves standby after 10 or 11 bit times high.
// - address-mark wakeup leaves standby on a character with msb set.
// - 16 samples per bit; sample disagreement sets noise flag with full flag.
// - missing stop bit sets framing error together with full flag.
// - character completing while buffer still full sets overrun flag.
// - 10 or 11 consecutive high bit times set the idle flag.
// - buffer-empty interrupt only while its enable bit is set.
// - full and overrun interrupts only while receive interrupt enable set.
// - empty flag clears by status read with flag set then data write.
// - full flag clears by status read with flag set then data read.
module asu_top (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // apb slave
  input  wire asu_pkg::asu_apb_req_t apb_i,
  output      asu_pkg::asu_apb_rsp_t apb_o,
  // serial line
  input  wire logic                 rx_data_pin,
  output      logic                 tx_data_pin,
  output      logic                 tx_data_oe,
  // interrupt request
  output      logic                 irq
);
  import asu_pkg::*;

  asu_state_t q;
  asu_state_t d;

  function automatic logic [2:0] asu_dec(input logic [7:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    unique case (a)
      ADDR_BAUD: s = SEL_BAUD;
      ADDR_CTLA: s = SEL_CTLA;
      ADDR_CTLB: s = SEL_CTLB;
      ADDR_STAT: s = SEL_STAT;
      ADDR_DATA: s = SEL_DATA;
      default:   s = SEL_NONE;
    endcase
    return s;
  endfunction

  logic        setup;
  logic        acc;
  logic [2:0]  sel;
  logic [7:0]  rb;
  logic        tick;
  logic        bit_tick;
  logic        te;
  logic        send_break;
  logic        re;
  logic        rx_wakeup_enable;
  logic [3:0]  ch_len;
  logic [3:0]  n_data;
  logic [7:0]  idle_thr;
  logic [10:0] frame;
  logic        vote;
  logic        rx_done;
  logic        rx_stop;
  logic        rx_msb;

  always_comb begin
    d = q;
    setup = apb_i.psel & ~apb_i.penable;
    acc = apb_i.psel & apb_i.penable & q.rsp.pready;
    sel = asu_dec(apb_i.paddr);
    te = q.ctlb[CTLB_TE];
    send_break = q.ctlb[CTLB_SBK];
    re = q.ctlb[CTLB_RE];
    rx_wakeup_enable = q.ctlb[CTLB_RWU];
    ch_len = q.m ? BITS_9 : BITS_8;
    n_data = q.m ? DATA_BITS_9 : DATA_BITS_8;
    idle_thr = q.m ? IDLE_THR_9 : IDLE_THR_8;
    frame = {1'b1, (q.m ? q.t8 : 1'b1), q.tx_buf, 1'b0};
    vote = (q.rx_s7 & q.rx_s8) | (q.rx_s7 & rx_data_pin) |
           (q.rx_s8 & rx_data_pin);
    rx_done = 1'b0;
    rx_stop = 1'b0;
    rx_msb = q.rx_sh[8];
    rb = 8'h00;

    // bus: answer one cycle after setup
    d.rsp.pready = 1'b0;
    if (setup) begin
      d.rsp.pready = 1'b1;
      d.rsp.pslverr = 1'b0;
      unique case (sel)
        SEL_BAUD: rb = q.baud;
        SEL_CTLA: rb = {q.r8, q.t8, 1'b0, q.m, q.wake, 3'h0};
        SEL_CTLB: rb = q.ctlb;
        SEL_STAT: rb = {q.tx_buffer_empty_flag, q.tc, q.rx_buffer_full_flag, q.idle, q.ovr, q.nf, q.fe,
                        1'b0};
        SEL_DATA: rb = q.rx_buf;
        default: begin
          rb = 8'h00;
          d.rsp.pslverr = 1'b1;
        end
      endcase
      d.rsp.prdata = {24'h000000, rb};
    end
    if (acc && apb_i.pwrite) begin
      unique case (sel)
        SEL_BAUD: d.baud = apb_i.pwdata[7:0];
        SEL_CTLA: begin
          d.t8 = apb_i.pwdata[CTLA_T8];
          d.m = apb_i.pwdata[CTLA_M];
          d.wake = apb_i.pwdata[CTLA_WAKE];
        end
        SEL_CTLB: d.ctlb = apb_i.pwdata[7:0];
        SEL_DATA: begin
          d.tx_buf = apb_i.pwdata[7:0];
          if (q.arm_tx) begin
            d.tx_buffer_empty_flag = 1'b0;
            d.tc = 1'b0;
            d.arm_tx = 1'b0;
          end
        end
        default: d.baud = q.baud;
      endcase
    end
    if (acc && !apb_i.pwrite) begin
      if (sel == SEL_STAT) begin
        if (q.tx_buffer_empty_flag || q.tc) d.arm_tx = 1'b1;
        if (q.rx_buffer_full_flag || q.idle || q.ovr) d.arm_rx = 1'b1;
      end
      if (sel == SEL_DATA && q.arm_rx) begin
        d.rx_buffer_full_flag = 1'b0;
        d.idle = 1'b0;
        d.ovr = 1'b0;
        d.nf = 1'b0;
        d.fe = 1'b0;
        d.arm_rx = 1'b0;
      end
    end

    // shared rate generator
    tick = (q.div == 8'h00);
    d.div = tick ? q.baud : q.div - 8'h01;
    bit_tick = tick & (q.tx_ph == PH_LAST);
    if (tick) d.tx_ph = q.tx_ph + 4'h1;

    // transmitter
    d.te_prev = te;
    if (te && !q.te_prev) begin
      d.pre_pend = 1'b1;
      d.tx_oe = 1'b1;
    end
    if (bit_tick) begin
      if (q.tx_cnt != 4'h0) begin
        d.tx_pin = q.tx_sh[0];
        d.tx_sh = {1'b1, q.tx_sh[10:1]};
        d.tx_cnt = q.tx_cnt - 4'h1;
        d.tx_line_idle = 1'b0;
      end else if (q.tx_oe) begin
        d.tx_line_idle = 1'b0;
        if (q.pre_pend) begin
          d.tx_pin = 1'b1;
          d.tx_sh = 11'h7ff;
          d.tx_cnt = ch_len - 4'h1;
          d.pre_pend = 1'b0;
          d.last_brk = 1'b0;
        end else if (send_break) begin
          d.tx_pin = 1'b0;
          d.tx_sh = 11'h000;
          d.tx_cnt = ch_len - 4'h1;
          d.last_brk = 1'b1;
        end else if (q.last_brk) begin
          d.tx_pin = 1'b1;
          d.last_brk = 1'b0;
        end else if (!q.tx_buffer_empty_flag) begin
          d.tx_pin = frame[0];
          d.tx_sh = {1'b1, frame[10:1]};
          d.tx_cnt = ch_len - 4'h1;
          d.tx_buffer_empty_flag = 1'b1;
        end else begin
          d.tx_pin = 1'b1;
          d.tx_line_idle = 1'b1;
          d.tc = 1'b1;
        end
      end
    end
    if (q.tx_oe && !te && q.tx_line_idle && q.tx_buffer_empty_flag && !send_break &&
        !q.pre_pend && !q.last_brk && q.tx_cnt == 4'h0 &&
        !(te && !q.te_prev)) begin
      d.tx_oe = 1'b0;
    end
    if (!d.tx_oe) begin
      d.tx_pin = 1'b1;
      d.tx_line_idle = 1'b1;
    end

    // receiver, sixteen samples per bit
    if (!re) begin
      d.rx_st = RX_IDLE;
      d.ones_cnt = 8'h00;
      d.rx_ph = 4'h0;
    end else if (tick) begin
      if (rx_data_pin) begin
        if (q.ones_cnt != idle_thr) d.ones_cnt = q.ones_cnt + 8'h01;
        if (q.ones_cnt == idle_thr - 8'h01) begin
          if (q.idle_armed) begin
            d.idle = 1'b1;
            d.idle_armed = 1'b0;
          end
          if (rx_wakeup_enable && !q.wake) d.ctlb[CTLB_RWU] = 1'b0;
        end
      end else begin
        d.ones_cnt = 8'h00;
        d.idle_armed = 1'b1;
      end
      unique case (q.rx_st)
        RX_IDLE: begin
          if (!rx_data_pin) begin
            d.rx_st = RX_START;
            d.rx_ph = 4'h1;
            d.rx_bit = 4'h0;
            d.rx_noise = 1'b0;
          end
        end
        RX_START, RX_DATA: begin
          d.rx_ph = q.rx_ph + 4'h1;
          if (q.rx_ph == PH_VOTE_A) d.rx_s7 = rx_data_pin;
          if (q.rx_ph == PH_VOTE_B) d.rx_s8 = rx_data_pin;
          if (q.rx_ph == PH_VOTE_C) begin
            if (!(q.rx_s7 == q.rx_s8 && q.rx_s8 == rx_data_pin)) begin
              d.rx_noise = 1'b1;
            end
            if (q.rx_st == RX_START) begin
              d.rx_st = vote ? RX_IDLE : RX_DATA;
            end else if (q.rx_bit == n_data) begin
              rx_done = 1'b1;
              rx_stop = vote;
              d.rx_st = RX_IDLE;
            end else begin
              d.rx_sh = {vote, q.rx_sh[8:1]};
              d.rx_bit = q.rx_bit + 4'h1;
            end
          end
        end
        default: d.rx_st = RX_IDLE;
      endcase
    end
    if (rx_done && (!rx_wakeup_enable || (q.wake && rx_msb))) begin
      d.ctlb[CTLB_RWU] = 1'b0;
      if (q.rx_buffer_full_flag) begin
        d.ovr = 1'b1;
      end else begin
        d.rx_buf = q.m ? q.rx_sh[7:0] : q.rx_sh[8:1];
        d.r8 = q.rx_sh[8];
        d.rx_buffer_full_flag = 1'b1;
        d.nf = q.rx_noise | d.rx_noise;
        d.fe = ~rx_stop;
      end
    end

    // interrupt request
    d.irq = (d.ctlb[CTLB_TIE] & d.tx_buffer_empty_flag) |
            (d.ctlb[CTLB_TX_COMPLETE_IRQ_ENABLE] & d.tc) |
            (d.ctlb[CTLB_RE] & ~d.ctlb[CTLB_RWU] &
             ((d.ctlb[CTLB_RIE] & (d.rx_buffer_full_flag | d.ovr)) |
              (d.ctlb[CTLB_IDLE_IRQ_ENABLE] & d.idle)));
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.baud <= BAUD_RST;
      q.ctlb <= CTLB_RST;
      q.tx_buffer_empty_flag <= TX_BUFFER_EMPTY_FLAG_RST;
      q.tc <= TC_RST;
      q.tx_pin <= 1'b1;
      q.tx_line_idle <= 1'b1;
      q.rx_st <= RX_IDLE;
      q.rx_s7 <= 1'b1;
      q.rx_s8 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign apb_o = q.rsp;
  assign tx_data_pin = q.tx_pin;
  assign tx_data_oe = q.tx_oe;
  assign irq = q.irq;

endmodule

// file: tb/asu_chk.sv
`timescale 1ns/100ps
module asu_chk (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  nrst,
  // bus and pins
  input wire asu_pkg::asu_apb_req_t apb_i,
  input wire asu_pkg::asu_apb_rsp_t apb_o,
  input wire logic                  tx_data_pin,
  input wire logic                  tx_data_oe,
  input wire logic                  irq
);
  import asu_pkg::*;
  logic [7:0] cb_q;
  logic       en_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // shadow of control_b as written over the bus
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cb_q <= 8'h00;
      en_q <= 1'b0;
    end else begin
      if (apb_o.pready && apb_i.pwrite && apb_i.paddr == ADDR_CTLB) begin
        cb_q <= apb_i.pwdata[7:0];
      end
      en_q <= |cb_q[7:4];
    end
  end
  sequence s_ones;
    tx_data_pin [*8];
  endsequence
  property p_idle;
    !tx_data_oe |-> tx_data_pin;
  endproperty
  property p_pre;
    $rose(tx_data_oe) |-> s_ones;
  endproperty
  property p_hold;
    $changed(tx_data_pin) |=> $stable(tx_data_pin) [*8];
  endproperty
  property p_on;
    $rose(tx_data_oe) |-> cb_q[CTLB_TE];
  endproperty
  property p_off;
    $fell(tx_data_oe) |-> !cb_q[CTLB_TE] && tx_data_pin;
  endproperty
  property p_irq;
    !(|cb_q[7:4]) && !en_q |-> !irq;
  endproperty
  property p_rdy;
    apb_i.psel && !apb_i.penable |=> apb_o.pready;
  endproperty
  property p_err;
    apb_o.pready && (apb_i.paddr < ADDR_BAUD || apb_i.paddr > ADDR_DATA)
      |-> apb_o.pslverr;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pin low undriven");
  a_pre: assert property (p_pre)
    else $error("no preamble");
  a_hold: assert property (p_hold)
    else $error("short bit");
  a_on: assert property (p_on)
    else $error("oe without enable");
  a_off: assert property (p_off)
    else $error("bad release");
  a_irq: assert property (p_irq)
    else $error("irq unmasked");
  a_rdy: assert property (p_rdy)
    else $error("no pready");
  a_err: assert property (p_err)
    else $error("no pslverr");
endmodule

bind asu_top asu_chk i_chk (
  .core_clk, .nrst, .apb_i, .apb_o, .tx_data_pin, .tx_data_oe, .irq
);

// file: tb/asu_line_model.sv
`timescale 1ns/100ps
module asu_line_model (
  // clock
  input  wire logic core_clk,
  // device pins
  input  wire logic tx_pin,
  input  wire logic tx_oe,
  output      logic rx_pin
);
  localparam int BT = 16;
  logic       nine = 1'b0;
  logic [8:0] got;
  int         frames = 0;
  int         breaks = 0;
  initial rx_pin = 1'b1;
  // one character lsb first, then one idle bit
  task automatic send(input logic [8:0] d, input logic stp, input logic nz);
    logic [10:0] fr;
    fr = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int p = 0; p < BT; p++) begin
        rx_pin <= fr[i] ^ (nz && i == 3 && p == 8);
        @(posedge core_clk);
      end
    end
    rx_pin <= 1'b1;
    repeat (BT) @(posedge core_clk);
  endtask
  // decode characters from the device line
  always begin
    @(posedge core_clk);
    if (tx_oe && !tx_pin) begin
      got = 9'h000;
      repeat (BT / 2) @(posedge core_clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BT) @(posedge core_clk);
        got[i] = tx_pin;
      end
      repeat (BT) @(posedge core_clk);
      if (tx_pin) frames++;
      else breaks++;
      wait (tx_pin);
    end
  end
endmodule

// file: tb/asu_top_test.sv
`timescale 1ns/100ps
module asu_top_test;
  import asu_pkg::*;
  logic         core_clk;
  logic         nrst;
  asu_apb_req_t apb_i;
  asu_apb_rsp_t apb_o;
  logic         rx_pin;
  logic         tx_pin;
  logic         tx_oe;
  logic         irq;
  logic [7:0]   rd;
  logic         err;
  int           mismatches = 0;
  int           checks_done = 0;

  asu_top i_dut (
    .core_clk, .nrst, .apb_i, .apb_o, .rx_data_pin(rx_pin),
    .tx_data_pin(tx_pin), .tx_data_oe(tx_oe), .irq
  );
  asu_line_model i_line (.core_clk, .tx_pin, .tx_oe, .rx_pin);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] s,
                     input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    int n;
    n = 0;
    apb_i <= '{1'b1, 1'b0, wr, a, {24'h0, wd}};
    @(posedge core_clk);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 40);
    if (n >= 40) mismatches++;
    rd = apb_o.prdata[7:0];
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {1'b0, rd & m}, {1'b0, e});
  endtask

  task automatic ichk(input string nm, input logic e);
    repeat (2) @(posedge core_clk);
    chk(nm, {8'h00, irq}, {8'h00, e});
  endtask

  task automatic tx(input logic [7:0] d);
    apb(1'b0, ADDR_STAT, 8'h00);
    apb(1'b1, ADDR_DATA, d);
  endtask

  task automatic wait_line(input logic brk, input int n);
    int k;
    k = 0;
    while ((brk ? i_line.breaks : i_line.frames) < n && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 4000) mismatches++;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    apb_i = '0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, ADDR_STAT, 8'h00);
    rchk("stat", ADDR_STAT, 8'hff, 8'hc0);
    apb(1'b1, 8'h00, 8'h11);
    chk("slverr", {8'h00, err}, 9'h001);
    apb(1'b1, ADDR_BAUD, 8'h5a);
    rchk("baud", ADDR_BAUD, 8'hff, 8'h5a);
    apb(1'b1, ADDR_BAUD, BAUD_RST);
    $display("regs done");
    apb(1'b1, ADDR_CTLB, 8'h08);
    tx(8'ha5);
    rchk("tx_buffer_empty_flag", ADDR_STAT, 8'h80, 8'h00);
    wait_line(1'b0, 1);
    chk("tx8", i_line.got, 9'h0a5);
    apb(1'b1, ADDR_CTLB, 8'h88);
    ichk("irq tie", 1'b1);
    apb(1'b1, ADDR_CTLB, 8'h08);
    ichk("irq mask", 1'b0);
    repeat (32) @(posedge core_clk);
    rchk("tc", ADDR_STAT, 8'hc0, 8'hc0);
    apb(1'b1, ADDR_CTLB, 8'h48);
    ichk("irq tc", 1'b1);
    apb(1'b1, ADDR_CTLB, 8'h08);
    apb(1'b1, ADDR_CTLA, 8'h50);
    i_line.nine = 1'b1;
    tx(8'h3c);
    wait_line(1'b0, 2);
    chk("tx9", i_line.got, 9'h13c);
    apb(1'b1, ADDR_CTLB, 8'h09);
    wait_line(1'b1, 1);
    apb(1'b1, ADDR_CTLB, 8'h08);
    tx(8'h81);
    wait_line(1'b0, 3);
    chk("post brk", i_line.got, 9'h181);
    tx(8'h42);
    apb(1'b1, ADDR_CTLB, 8'h00);
    wait_line(1'b0, 4);
    chk("last", i_line.got, 9'h142);
    repeat (64) @(posedge core_clk);
    chk("oe off", {8'h00, tx_oe}, 9'h000);
    $display("tx done");
    i_line.nine = 1'b0;
    apb(1'b1, ADDR_CTLA, 8'h00);
    apb(1'b1, ADDR_CTLB, 8'h24);
    i_line.send(9'h05a, 1'b1, 1'b0);
    ichk("irq rx", 1'b1);
    rchk("rx_buffer_full_flag", ADDR_STAT, 8'h2e, 8'h20);
    rchk("rx8", ADDR_DATA, 8'hff, 8'h5a);
    rchk("rx_buffer_full_flag clr", ADDR_STAT, 8'h20, 8'h00);
    i_line.send(9'h033, 1'b1, 1'b1);
    rchk("noise", ADDR_STAT, 8'h06, 8'h04);
    i_line.send(9'h00f, 1'b1, 1'b0);
    rchk("overrun", ADDR_STAT, 8'h08, 8'h08);
    rchk("kept", ADDR_DATA, 8'hff, 8'h33);
    i_line.send(9'h0f0, 1'b0, 1'b0);
    rchk("framing", ADDR_STAT, 8'h22, 8'h22);
    repeat (400) @(posedge core_clk);
    rchk("idle", ADDR_STAT, 8'h10, 8'h10);
    apb(1'b1, ADDR_CTLB, 8'h14);
    ichk("irq idle", 1'b1);
    apb(1'b0, ADDR_DATA, 8'h00);
    i_line.nine = 1'b1;
    apb(1'b1, ADDR_CTLA, 8'h18);
    apb(1'b1, ADDR_CTLB, 8'h26);
    i_line.send(9'h011, 1'b1, 1'b0);
    ichk("standby", 1'b0);
    i_line.send(9'h1ab, 1'b1, 1'b0);
    rchk("mark wake", ADDR_CTLB, 8'h02, 8'h00);
    rchk("r8", ADDR_CTLA, 8'h80, 8'h80);
    apb(1'b1, ADDR_CTLA, 8'h10);
    apb(1'b1, ADDR_CTLB, 8'h26);
    ichk("standby full", 1'b0);
    i_line.send(9'h011, 1'b1, 1'b0);
    repeat (400) @(posedge core_clk);
    rchk("idle wake", ADDR_CTLB, 8'h02, 8'h00);
    ichk("wake irq", 1'b1);
    $display("rx done");
    close_out();
  end
endmodule
